// [port2_phy_ctrl.sv]
`timescale 1ns/1ps
`include "port2_phy_cfg.svh"
// Notes on behaviour
// - Bit 15 of diagnostic register reads one for a short under ten meters.
// - Bits 14:13 give test outcome: normal, open, short, failed.
// - Writing one to bit 12 starts the test; hardware clears it when done.
// - Bits 8:0 hold the fault count; distance is about count times 0.4 m.
// - Diagnostic bit 11 forces the link state to pass.
// - Diagnostic bit 10 disables power saving; it resets to one.
// - Diagnostic bit 9 loops received line signal back out locally.
// - Control bit 15 blanks all four LEDs by driving them high.
// - Control bit 14 disables transmitter, bit 11 powers down; both reset zero.
// - Writing one to control bit 13 restarts auto-negotiation.
// - Bit 10 disables auto crossover; then bit 9 forces crossover mode.
// - Control bit 8 enables far-end loopback through the other port.
// - Bit 7 enables auto-negotiation, resets one; else bits 6:5 decide.
// - With negotiation off, bit 6 picks 100 or 10 megabit; resets zero.
// - Bit 5 forces duplex when negotiation is off or has failed.
// - Bit 4 advertises pause capability; resets to one.
// - Bits 3:0 select advertised speed and duplex abilities; reset one.
// - Diagnostic fields share storage with two alias addresses.
module port2_phy_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire port2_phy_pkg::wb_req_t wb_req_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic cdt_start_out,
  input wire logic cdt_done_in,
  input wire port2_phy_pkg::cdt_res_t cdt_res_in,
  input wire logic an_failed_in,
  input wire logic an_speed_in,
  input wire logic an_duplex_in,
  input wire logic [3:0] port2_led_in,
  output logic port2_led_out0,
  output logic port2_led_out1,
  output logic port2_led_out2,
  output logic port2_led_out3,
  output logic force_link_out,
  output logic power_save_en_out,
  output logic near_loop_out,
  output logic far_loop_out,
  output logic tx_disable_out,
  output logic power_down_out,
  output logic an_restart_out,
  output logic an_enable_out,
  output logic speed_100_out,
  output logic full_duplex_out,
  output logic mdix_auto_dis_out,
  output logic mdix_force_out,
  output logic [4:0] advertise_out
);
  import port2_phy_pkg::*;

  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr == {idx, 2'b00});
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
    input logic [31:0] wdat, input logic [3:0] sel);
    merge = {sel[1] ? wdat[15:8] : old[15:8],
      sel[0] ? wdat[7:0] : old[7:0]};
  endfunction

  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  cdt_st_t st_ff, nxt_st;
  cdt_res_t res_ff, nxt_res;
  logic flink_ff, nxt_flink;
  logic psave_dis_ff, nxt_psave_dis;
  logic nloop_ff, nxt_nloop;
  logic [15:0] ctl_ff, nxt_ctl;
  logic anrst_ff, nxt_anrst;
  logic dpx_ff, nxt_dpx;
  logic spd_ff, nxt_spd;
  logic [3:0] led_ff, nxt_led;
  logic req, wr, busy;
  logic [15:0] diag_rd, ctl_rd, dalias_rd, lalias_rd;
  logic [15:0] wdiag, wctl, wdal, wlal;
  logic wr_diag, wr_ctl, wr_dal, wr_lal, start_req;

  // A request is answered once; ack drops the cycle after it rose.
  assign req = wb_req_in.cyc & wb_req_in.stb & ~ack_ff;
  assign wr = req & wb_req_in.we;
  assign wr_diag = wr & hit(wb_req_in.adr, `IDX_DIAG);
  assign wr_ctl = wr & hit(wb_req_in.adr, `IDX_CTL4);
  assign wr_dal = wr & hit(wb_req_in.adr, `IDX_DIAG_ALIAS);
  assign wr_lal = wr & hit(wb_req_in.adr, `IDX_LINK_ALIAS);
  assign busy = (st_ff != ST_IDLE);

  always_comb begin
    diag_rd = 16'h0000;
    diag_rd[`D_SHORT] = res_ff.near_short;
    diag_rd[`D_RES_HI:`D_RES_LO] = res_ff.code;
    diag_rd[`D_START] = busy;
    diag_rd[`D_FLINK] = flink_ff;
    diag_rd[`D_PSAVE_DIS] = psave_dis_ff;
    diag_rd[`D_NLOOP] = nloop_ff;
    diag_rd[`D_CNT_HI:0] = res_ff.count;
    dalias_rd = 16'h0000;
    dalias_rd[`A_START] = busy;
    dalias_rd[`A_RES_HI:`A_RES_LO] = res_ff.code;
    dalias_rd[`A_SHORT] = res_ff.near_short;
    dalias_rd[`D_CNT_HI:0] = res_ff.count;
    lalias_rd = 16'h0000;
    lalias_rd[`A_FLINK] = flink_ff;
    lalias_rd[`A_PSAVE_DIS] = psave_dis_ff;
    lalias_rd[`A_NLOOP] = nloop_ff;
    ctl_rd = ctl_ff;
    wdiag = merge(diag_rd, wb_req_in.dat, wb_req_in.sel);
    wctl = merge(ctl_ff, wb_req_in.dat, wb_req_in.sel);
    wdal = merge(dalias_rd, wb_req_in.dat, wb_req_in.sel);
    wlal = merge(lalias_rd, wb_req_in.dat, wb_req_in.sel);
  end

  // Bus slave: one wait-free cycle, unmapped reads return zero.
  always_comb begin
    nxt_ack = req;
    nxt_dat = 32'h0000_0000;
    if (req && !wb_req_in.we) begin
      if (hit(wb_req_in.adr, `IDX_DIAG)) begin
        nxt_dat = {16'h0000, diag_rd};
      end else if (hit(wb_req_in.adr, `IDX_CTL4)) begin
        nxt_dat = {16'h0000, ctl_rd};
      end else if (hit(wb_req_in.adr, `IDX_DIAG_ALIAS)) begin
        nxt_dat = {16'h0000, dalias_rd};
      end else if (hit(wb_req_in.adr, `IDX_LINK_ALIAS)) begin
        nxt_dat = {16'h0000, lalias_rd};
      end
    end else if (req) begin
      nxt_dat = wb_dat_out;
    end else if (!ack_ff) begin
      nxt_dat = wb_dat_out;
    end
  end

  // A start written while a test runs is ignored, so it cannot be aborted.
  assign start_req = (wr_diag && wdiag[`D_START]) ||
    (wr_dal && wdal[`A_START]);

  always_comb begin
    nxt_st = st_ff;
    nxt_res = res_ff;
    case (st_ff)
      ST_IDLE: begin
        if (start_req) begin
          nxt_st = ST_LAUNCH;
          nxt_res = '0;
        end
      end
      ST_LAUNCH: begin
        nxt_st = ST_WAIT;
      end
      ST_WAIT: begin
        if (cdt_done_in) begin
          nxt_st = ST_IDLE;
          nxt_res = cdt_res_in;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_flink = flink_ff;
    nxt_psave_dis = psave_dis_ff;
    nxt_nloop = nloop_ff;
    if (wr_diag) begin
      nxt_flink = wdiag[`D_FLINK];
      nxt_psave_dis = wdiag[`D_PSAVE_DIS];
      nxt_nloop = wdiag[`D_NLOOP];
    end else if (wr_lal) begin
      nxt_flink = wlal[`A_FLINK];
      nxt_psave_dis = wlal[`A_PSAVE_DIS];
      nxt_nloop = wlal[`A_NLOOP];
    end
  end

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_anrst = 1'b0;
    if (wr_ctl) begin
      nxt_ctl = wctl;
      nxt_ctl[`C_RSVD] = 1'b0;
      nxt_anrst = wctl[`C_ANRST];
    end
  end

  // Forced values apply with negotiation off; duplex also on failure.
  always_comb begin
    nxt_spd = an_speed_in;
    nxt_dpx = an_duplex_in;
    if (!ctl_ff[`C_ANEN]) begin
      nxt_spd = ctl_ff[`C_SPD];
      nxt_dpx = ctl_ff[`C_DPX];
    end else if (an_failed_in) begin
      nxt_dpx = ctl_ff[`C_DPX];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_led
      always_comb begin
        nxt_led[gi] = ctl_ff[`C_LEDOFF] | port2_led_in[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      st_ff <= ST_IDLE;
      res_ff <= '0;
      flink_ff <= 1'(`DIAG_RST >> `D_FLINK);
      psave_dis_ff <= 1'(`DIAG_RST >> `D_PSAVE_DIS);
      nloop_ff <= 1'(`DIAG_RST >> `D_NLOOP);
      ctl_ff <= `CTL4_RST;
      anrst_ff <= 1'b0;
      dpx_ff <= 1'b0;
      spd_ff <= 1'b0;
      led_ff <= 4'hf;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      st_ff <= nxt_st;
      res_ff <= nxt_res;
      flink_ff <= nxt_flink;
      psave_dis_ff <= nxt_psave_dis;
      nloop_ff <= nxt_nloop;
      ctl_ff <= nxt_ctl;
      anrst_ff <= nxt_anrst;
      dpx_ff <= nxt_dpx;
      spd_ff <= nxt_spd;
      led_ff <= nxt_led;
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = dat_ff;
  assign cdt_start_out = (st_ff == ST_LAUNCH);
  assign force_link_out = flink_ff;
  assign power_save_en_out = ~psave_dis_ff;
  assign near_loop_out = nloop_ff;
  assign far_loop_out = ctl_ff[`C_FLOOP];
  assign tx_disable_out = ctl_ff[`C_TXDIS];
  assign power_down_out = ctl_ff[`C_PDOWN];
  assign an_restart_out = anrst_ff;
  assign an_enable_out = ctl_ff[`C_ANEN];
  assign speed_100_out = spd_ff;
  assign full_duplex_out = dpx_ff;
  assign mdix_auto_dis_out = ctl_ff[`C_MDIX_DIS];
  // Forcing crossover only counts while automatic detection is off.
  assign mdix_force_out = ctl_ff[`C_MDIX_DIS] & ctl_ff[`C_MDIX_FRC];
  assign advertise_out = ctl_ff[`C_ADV_HI:0];
  assign port2_led_out0 = led_ff[0];
  assign port2_led_out1 = led_ff[1];
  assign port2_led_out2 = led_ff[2];
  assign port2_led_out3 = led_ff[3];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_START_LAUNCH: assert property (
    (st_ff == ST_IDLE) && start_req |=> cdt_start_out ##1 !cdt_start_out)
    else $error("Cable test start not launched.");
  AST_SELF_CLEAR: assert property (
    (st_ff == ST_WAIT) && cdt_done_in |=> !busy && !cdt_start_out)
    else $error("Start bit not cleared after test end.");
  AST_SHORT_CAPT: assert property (
    (st_ff == ST_WAIT) && cdt_done_in
    |=> res_ff.near_short == $past(cdt_res_in.near_short))
    else $error("Short flag not captured.");
  AST_CODE_CAPT: assert property (
    (st_ff == ST_WAIT) && cdt_done_in
    |=> diag_rd[14:13] == $past(cdt_res_in.code))
    else $error("Result code not captured.");
  AST_COUNT_CAPT: assert property (
    (st_ff == ST_WAIT) && cdt_done_in
    |=> diag_rd[8:0] == $past(cdt_res_in.count))
    else $error("Fault count not captured.");
  AST_HOLD: assert property (
    (st_ff == ST_IDLE) && !start_req |=> $stable(res_ff))
    else $error("Results changed without a new test.");
  AST_FLINK: assert property (
    wr_diag && wb_req_in.sel[1]
    |=> force_link_out == $past(wb_req_in.dat[11]))
    else $error("Force link write not applied.");
  AST_LED_OFF: assert property (
    ctl_ff[15] |=> port2_led_out0 && port2_led_out1 &&
      port2_led_out2 && port2_led_out3)
    else $error("LEDs not blanked.");
  AST_DPX: assert property (
    !ctl_ff[7] && $stable(ctl_ff) |=> full_duplex_out == $past(ctl_ff[5]))
    else $error("Forced duplex not applied.");
  AST_RESTART: assert property (
    wr_ctl && wb_req_in.sel[1] && wb_req_in.dat[13]
    |=> an_restart_out ##1 !an_restart_out || $past(wr_ctl))
    else $error("Negotiation restart pulse missing.");
  AST_ALIAS: assert property (
    diag_rd[12] == dalias_rd[15] && diag_rd[8:0] == dalias_rd[8:0])
    else $error("Alias view differs.");
  AST_BUSY_IGNORE: assert property (
    busy && start_req |=> st_ff != ST_LAUNCH)
    else $error("Start accepted while a test runs.");
  AST_RES_CLEAR: assert property (
    (st_ff == ST_IDLE) && start_req |=> res_ff == '0)
    else $error("Results not cleared at test start.");
  AST_PSAVE: assert property (
    wr_diag && wb_req_in.sel[1]
    |=> power_save_en_out == !$past(wb_req_in.dat[10]))
    else $error("Power saving write not applied.");
  AST_NLOOP: assert property (
    wr_diag && wb_req_in.sel[1]
    |=> near_loop_out == $past(wb_req_in.dat[9]))
    else $error("Near-end loopback write not applied.");
  // The guard skips the cycle whose LED register still holds its reset value.
  AST_LED_ON: assert property (
    !ctl_ff[15] && !$past(rst_in) |=> {port2_led_out3, port2_led_out2,
      port2_led_out1, port2_led_out0} == $past(port2_led_in))
    else $error("LEDs do not follow their normal levels.");
  AST_TXDIS: assert property (
    wr_ctl && wb_req_in.sel[1]
    |=> tx_disable_out == $past(wb_req_in.dat[14]) &&
      power_down_out == $past(wb_req_in.dat[11]))
    else $error("Transmit disable or power down not applied.");
  AST_MDIX: assert property (
    wr_ctl && wb_req_in.sel[1]
    |=> mdix_auto_dis_out == $past(wb_req_in.dat[10]) &&
      mdix_force_out == ($past(wb_req_in.dat[10]) &&
      $past(wb_req_in.dat[9])))
    else $error("Crossover control not applied.");
  AST_FLOOP: assert property (
    wr_ctl && wb_req_in.sel[1]
    |=> far_loop_out == $past(wb_req_in.dat[8]))
    else $error("Far-end loopback write not applied.");
  AST_ANEN: assert property (
    wr_ctl && wb_req_in.sel[0]
    |=> an_enable_out == $past(wb_req_in.dat[7]))
    else $error("Negotiation enable write not applied.");
  AST_SPD: assert property (
    !ctl_ff[7] |=> speed_100_out == $past(ctl_ff[6]))
    else $error("Forced speed not applied.");
  AST_DPX_FAIL: assert property (
    ctl_ff[7] && an_failed_in
    |=> full_duplex_out == $past(ctl_ff[5]))
    else $error("Duplex after failed negotiation not applied.");
  AST_ADV: assert property (
    wr_ctl && wb_req_in.sel[0]
    |=> advertise_out == $past(wb_req_in.dat[4:0]))
    else $error("Advertised abilities not applied.");
  AST_ALIAS_START: assert property (
    (st_ff == ST_IDLE) && wr_dal && wb_req_in.sel[1] && wb_req_in.dat[15]
    |=> dalias_rd[15] && diag_rd[12])
    else $error("Start through the alias not seen.");
  AST_LINK_ALIAS: assert property (
    wr_lal && wb_req_in.sel[0]
    |=> force_link_out == $past(wb_req_in.dat[3]))
    else $error("Force link write through the alias not applied.");

  CV_TEST_DONE: cover property (
    (st_ff == ST_WAIT) && cdt_done_in ##1 !busy);
  CV_LED_OFF: cover property (wr_ctl ##1 ctl_ff[15]);
  CV_FORCED: cover property (!ctl_ff[7] && ctl_ff[6]);
  CV_ALIAS_START: cover property (wr_dal && wdal[15] && !busy);
  CV_AN_FAILED: cover property (ctl_ff[7] && an_failed_in ##1 full_duplex_out);

endmodule // port2_phy_ctrl

// [port2_phy_cfg.svh]
`ifndef PORT2_PHY_CFG_SVH
`define PORT2_PHY_CFG_SVH
`define IDX_DIAG 6'h00
`define IDX_CTL4 6'h02
`define IDX_DIAG_ALIAS 6'h04
`define IDX_LINK_ALIAS 6'h06
`define DIAG_RST 16'h0400
`define CTL4_RST 16'h00bf
`define D_SHORT 15
`define D_RES_HI 14
`define D_RES_LO 13
`define D_START 12
`define D_FLINK 11
`define D_PSAVE_DIS 10
`define D_NLOOP 9
`define D_CNT_HI 8
`define C_LEDOFF 15
`define C_TXDIS 14
`define C_ANRST 13
`define C_RSVD 12
`define C_PDOWN 11
`define C_MDIX_DIS 10
`define C_MDIX_FRC 9
`define C_FLOOP 8
`define C_ANEN 7
`define C_SPD 6
`define C_DPX 5
`define C_ADV_HI 4
`define A_START 15
`define A_RES_HI 14
`define A_RES_LO 13
`define A_SHORT 12
`define A_FLINK 3
`define A_PSAVE_DIS 2
`define A_NLOOP 1
`endif

// [port2_phy_pkg.sv]
package port2_phy_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic near_short;
    logic [1:0] code;
    logic [8:0] count;
  } cdt_res_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAUNCH = 2'b01,
    ST_WAIT = 2'b11
  } cdt_st_t;
endpackage

// [port2_cdt_model.sv]
`timescale 1ns/1ps
module port2_cdt_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [7:0] delay_in,
  input wire port2_phy_pkg::cdt_res_t res_in,
  output logic done_out,
  output port2_phy_pkg::cdt_res_t res_out
);
  import port2_phy_pkg::*;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  // Results are inverted outside the done cycle, so late sampling fails.
  assign done_out = (cnt_ff == 8'h01);
  assign res_out = done_out ? res_in : cdt_res_t'(~res_in);
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start_in) begin
      nxt_cnt = delay_in;
    end else if (cnt_ff != 8'h00) begin
      nxt_cnt = cnt_ff - 8'h01;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // port2_cdt_model

// [tb_port2_phy_ctrl.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin \
  check_count++; \
  if ((sn) !== (ex)) begin \
    errors++; \
    $display("Error %s expected %h seen %h", nm, ex, sn); \
  end \
end
module tb_port2_phy_ctrl;
  import port2_phy_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  wb_req_t req = '0;
  cdt_res_t res_set = '0;
  cdt_res_t res_eng;
  logic an_f = 1'b0;
  logic an_s = 1'b0;
  logic an_d = 1'b0;
  logic [3:0] led_in = 4'h0;
  logic [7:0] dly = 8'h08;
  logic ack, start, done, an_rst, flink, psave, nloop, floop, txd;
  logic pdn, anen, spd, fdx, mdis, mfrc;
  logic [3:0] led;
  logic [4:0] adv;
  logic [31:0] rdat;
  logic [31:0] wdo;
  logic [31:0] seed = 32'h0001347b;
  logic [15:0] v;
  int errors = 0;
  int check_count = 0;
  int rst_cnt = 0;
  int c0, n;
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (an_rst === 1'b1) rst_cnt++;
  port2_phy_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .wb_req_in(req),
    .wb_ack_out(ack), .wb_dat_out(wdo), .cdt_start_out(start),
    .cdt_done_in(done), .cdt_res_in(res_eng), .an_failed_in(an_f),
    .an_speed_in(an_s), .an_duplex_in(an_d), .port2_led_in(led_in),
    .port2_led_out0(led[0]), .port2_led_out1(led[1]),
    .port2_led_out2(led[2]), .port2_led_out3(led[3]),
    .force_link_out(flink), .power_save_en_out(psave),
    .near_loop_out(nloop), .far_loop_out(floop), .tx_disable_out(txd),
    .power_down_out(pdn), .an_restart_out(an_rst), .an_enable_out(anen),
    .speed_100_out(spd), .full_duplex_out(fdx), .mdix_auto_dis_out(mdis),
    .mdix_force_out(mfrc), .advertise_out(adv));
  port2_cdt_model engine (.clk_in(clk_in), .rst_in(rst_in),
    .start_in(start), .delay_in(dly), .res_in(res_set), .done_out(done),
    .res_out(res_eng));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_spd(input logic [15:0] c);
    return c[7] ? an_s : c[6];
  endfunction
  function automatic logic exp_dpx(input logic [15:0] c);
    return (!c[7] || an_f) ? c[5] : an_d;
  endfunction
  task automatic print_verdict;
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The master waits for ack, however late; only the watchdog ends it.
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req <= '{1'b1, 1'b1, w, a, 4'h3, {16'h0000, d}};
    do @(posedge clk_in); while (ack !== 1'b1);
    rdat = wdo;
    req <= '0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    wb(1'b0, 8'h00, 16'h0000);
    `CHK("diag", 32'h00000400, rdat)
    `CHK("psave", 1'b0, psave)
    wb(1'b0, 8'h08, 16'h0000);
    `CHK("ctl", 32'h000000bf, rdat)
    wb(1'b0, 8'h20, 16'h0000);
    `CHK("unmapped", 32'h00000000, rdat)
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : seed[15:0];
      an_f <= seed[16];
      an_s <= seed[17];
      an_d <= seed[18];
      led_in <= seed[22:19];
      if (v[7] && !seed[16]) v[5] = 1'b0;
      c0 = rst_cnt;
      wb(1'b1, 8'h08, v);
      repeat (3) @(posedge clk_in);
      #1;
      `CHK("led", v[15] ? 4'hf : led_in, led)
      `CHK("txd pdn", {v[14], v[11]}, {txd, pdn})
      `CHK("restart", int'(v[13]), rst_cnt - c0)
      `CHK("mdix", {v[10], v[10] & v[9]}, {mdis, mfrc})
      `CHK("far loop", v[8], floop)
      `CHK("an en", v[7], anen)
      `CHK("speed", exp_spd(v), spd)
      `CHK("duplex", exp_dpx(v), fdx)
      `CHK("adv", v[4:0], adv)
      wb(1'b0, 8'h08, 16'h0000);
      `CHK("ctl rd", {16'h0000, v & 16'hefff}, rdat)
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = seed[15:0] & 16'hefff;
      wb(1'b1, (i == 7) ? 8'h18 : 8'h00,
        (i == 7) ? {12'h000, v[11:9], 1'b0} : v);
      wb(1'b0, 8'h00, 16'h0000);
      `CHK("diag rw", {16'h0000, v & 16'h0e00}, rdat)
      `CHK("diag out", {v[11], ~v[10], v[9]}, {flink, psave, nloop})
      wb(1'b0, 8'h18, 16'h0000);
      `CHK("link alias", {28'h0, v[11:9], 1'b0}, rdat)
    end
    wb(1'b1, 8'h00, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      res_set <= '{seed[0], 2'(k), (k == 3) ? 9'h1ff : seed[8:0]};
      dly <= {4'h0, seed[13:10]} + 8'h08;
      wb(1'b1, (k == 3) ? 8'h10 : 8'h00, (k == 3) ? 16'h8000 : 16'h1000);
      wb(1'b0, 8'h00, 16'h0000);
      `CHK("busy", 32'h00001000, rdat)
      n = 0;
      do begin
        wb(1'b0, 8'h00, 16'h0000);
        n++;
      end while (rdat[12] !== 1'b0 && n < 60);
      `CHK("result", {16'h0, res_set[11:9], 4'h0, res_set[8:0]}, rdat)
      wb(1'b0, 8'h10, 16'h0000);
      `CHK("alias", {16'h0, 1'b0, res_set[10:9], res_set[11], 3'h0,
        res_set[8:0]}, rdat)
      wb(1'b1, 8'h00, 16'h0000);
      repeat (20) @(posedge clk_in);
      wb(1'b0, 8'h00, 16'h0000);
      `CHK("hold", {16'h0, res_set[11:9], 4'h0, res_set[8:0]}, rdat)
    end
    print_verdict();
  end
endmodule // tb_port2_phy_ctrl
